// ---- rtl/mrf_pkg.sv ----
// Constants and types shared by the response framer files
package mrf_pkg;

  // ****************************************************************
  // Response frame layout (byte offsets)
  // ****************************************************************
  localparam logic [8:0] RSP_OFS_SEQ     = 9'h000;
  localparam logic [8:0] RSP_OFS_SIZE    = 9'h002;
  localparam logic [8:0] RSP_OFS_RSVD    = 9'h004;
  localparam logic [8:0] RSP_OFS_SVC     = 9'h005;
  localparam logic [8:0] RSP_OFS_STATUS  = 9'h006;
  localparam logic [8:0] RSP_OFS_ADDL    = 9'h007;
  localparam logic [8:0] RSP_OFS_PAYLOAD = 9'h008;

  // ****************************************************************
  // Sizes and limits
  // ****************************************************************
  localparam logic [15:0] RSP_SIZE_BASE     = 16'h0004; // Reserved..general/addl fields
  localparam logic [16:0] CMD_SIZE_BASE     = 17'h0_0006; // Bytes before command size span
  localparam logic [15:0] MAX_RX_FRAME      = 16'h01F8; // 504 bytes
  localparam int unsigned MAX_PAYLOAD_BYTES = 496;
  localparam int unsigned PAYLOAD_AW        = 9;

  // ****************************************************************
  // Field values
  // ****************************************************************
  localparam logic [7:0] RSVD_VALUE   = 8'h00;
  localparam logic [7:0] SVC_REPLY    = 8'h80;
  localparam logic [7:0] STATUS_OK    = 8'h00;
  localparam logic [7:0] STATUS_SHORT = 8'h13;
  localparam logic [7:0] STATUS_LONG  = 8'h15;

  // ****************************************************************
  // Control states
  // ****************************************************************
  typedef enum logic [2:0] {
    MRF_IDLE,
    MRF_COLLECT,
    MRF_FETCH,
    MRF_LOAD,
    MRF_PRESENT
  } mrf_state_type;

endpackage

// ---- rtl/mrf_mem_if.sv ----
// Interface between framer and payload memory
`timescale 1ns/1ns
`default_nettype none
interface mrf_mem_if #(
  parameter int unsigned AW = 9
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;

  modport framer (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
  modport mem    (input wr_en, input wr_addr, input wr_data,
                  input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- rtl/mrf_payload_mem.sv ----
// Payload byte store with registered read data
`timescale 1ns/1ns
`default_nettype none
module mrf_payload_mem import mrf_pkg::*; #(
  parameter int unsigned DEPTH = MAX_PAYLOAD_BYTES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  // Memory port
  mrf_mem_if.mem    mem
);

  logic [7:0] store [DEPTH];

  // ****************************************************************
  // Write port
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (mem.wr_en) begin
      store[mem.wr_addr] <= mem.wr_data;
    end
  end

  // ****************************************************************
  // Read port, one cycle latency
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem.rd_data <= 8'h00;
    end else if (mem.rd_en) begin
      mem.rd_data <= store[mem.rd_addr];
    end
  end

endmodule // mrf_payload_mem
`default_nettype wire

// ---- rtl/mrf_framer.sv ----
// Response frame builder for the request/response message service
// Notes on behaviour
// - Response bytes are sequence(2), size(2), zero reserved, service, status, additional count, then payload.
// - The command sequence number is echoed unchanged into the response.
// - The size field counts reserved byte through payload end and stays within 4 to 500.
// - On success the service byte is the requested code with its top bit set.
// - The additional count byte gives the number of 16-bit words in the additional status array.
// - With zero status the payload carries up to 496 result bytes.
// - With nonzero status the payload carries the additional status array instead.
// - Multi-byte fields go out low byte first, and the client sends them the same way.
// - A frame over 504 bytes or with a wrong size field is answered with status 0x13.
// - A wrong size field may instead be answered with status 0x15.
`timescale 1ns/1ns
`default_nettype none
module mrf_framer import mrf_pkg::*; #(
  parameter int unsigned PAYLOAD_MAX = MAX_PAYLOAD_BYTES
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Parsed command
  input  wire logic        cmd_valid_i,
  input  wire logic [15:0] cmd_seq_i,
  input  wire logic [7:0]  cmd_svc_i,
  input  wire logic [15:0] cmd_size_i,
  input  wire logic [15:0] cmd_rx_bytes_i,
  output logic             cmd_ready_o,
  // Error code choice for size mismatch
  input  wire logic        mismatch_long_i,
  // Service result
  input  wire logic        res_valid_i,
  input  wire logic [7:0]  res_data_i,
  output logic             res_ready_o,
  input  wire logic        res_done_i,
  input  wire logic [7:0]  res_status_i,
  // Response byte stream
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i,
  // Error events
  output logic             frame_short_error_o,
  output logic             frame_long_error_o
);

  // ****************************************************************
  // State and captured fields
  // ****************************************************************
  mrf_state_type   state;
  logic [15:0]     seq;
  logic [7:0]      svc;
  logic [7:0]      status;
  logic [7:0]      addl_words;
  logic [8:0]      plen;
  logic [8:0]      wcount;
  logic [8:0]      idx;
  logic [8:0]      next_wcount;
  logic [8:0]      done_plen;
  logic            wr_take;
  logic            oversize;
  logic            mismatch;
  logic [15:0]     rsp_size;

  mrf_mem_if #(.AW(PAYLOAD_AW)) mem_bus ();

  // ****************************************************************
  // Header byte lookup
  // ****************************************************************
  function automatic logic [7:0] hdr_byte(input logic [8:0] ofs, input logic [15:0] sq,
                                           input logic [15:0] sz, input logic [7:0] sv,
                                           input logic [7:0] st, input logic [7:0] ad);
    logic [7:0] b;
    b = RSVD_VALUE;
    if (ofs == RSP_OFS_SEQ) begin
      b = sq[7:0];
    end else if (ofs == RSP_OFS_SEQ + 9'h001) begin
      b = sq[15:8];
    end else if (ofs == RSP_OFS_SIZE) begin
      b = sz[7:0];
    end else if (ofs == RSP_OFS_SIZE + 9'h001) begin
      b = sz[15:8];
    end else if (ofs == RSP_OFS_RSVD) begin
      b = RSVD_VALUE;
    end else if (ofs == RSP_OFS_SVC) begin
      b = sv;
    end else if (ofs == RSP_OFS_STATUS) begin
      b = st;
    end else if (ofs == RSP_OFS_ADDL) begin
      b = ad;
    end
    return b;
  endfunction

  // ****************************************************************
  // Command checks
  // ****************************************************************
  assign oversize = cmd_rx_bytes_i > MAX_RX_FRAME;
  assign mismatch = (17'(cmd_size_i) + CMD_SIZE_BASE) != 17'(cmd_rx_bytes_i);

  // ****************************************************************
  // Result collection and payload length
  // ****************************************************************
  assign wr_take     = (state == MRF_COLLECT) && res_valid_i && (32'(wcount) < PAYLOAD_MAX);
  assign next_wcount = wcount + {8'h00, wr_take};
  assign done_plen   = (res_status_i == STATUS_OK) ? next_wcount : {next_wcount[8:1], 1'b0};
  assign rsp_size    = RSP_SIZE_BASE + {7'h00, plen};

  // Payload memory connections
  assign mem_bus.wr_en   = wr_take;
  assign mem_bus.wr_addr = wcount;
  assign mem_bus.wr_data = res_data_i;
  // Header bytes skip the store so no read runs past its last word
  assign mem_bus.rd_en   = (state == MRF_FETCH) && (idx >= RSP_OFS_PAYLOAD);
  assign mem_bus.rd_addr = idx - RSP_OFS_PAYLOAD;

  mrf_payload_mem #(
    .DEPTH (PAYLOAD_MAX)
  ) u_mem (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .mem      (mem_bus)
  );

  // ****************************************************************
  // Sequencer and captured response fields
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state      <= MRF_IDLE;
      seq        <= 16'h0000;
      svc        <= 8'h00;
      status     <= STATUS_OK;
      addl_words <= 8'h00;
      plen       <= 9'h000;
      wcount     <= 9'h000;
      idx        <= 9'h000;
    end else begin
      case (state)
        MRF_IDLE: begin
          if (cmd_valid_i) begin
            seq        <= cmd_seq_i;
            svc        <= cmd_svc_i;
            wcount     <= 9'h000;
            idx        <= 9'h000;
            addl_words <= 8'h00;
            plen       <= 9'h000;
            if (oversize || (mismatch && !mismatch_long_i)) begin
              status <= STATUS_SHORT;
              state  <= MRF_FETCH;
            end else if (mismatch) begin
              status <= STATUS_LONG;
              state  <= MRF_FETCH;
            end else begin
              state <= MRF_COLLECT;
            end
          end
        end
        MRF_COLLECT: begin
          wcount <= next_wcount;
          if (res_done_i) begin
            status <= res_status_i;
            plen   <= done_plen;
            if (res_status_i == STATUS_OK) begin
              svc        <= svc | SVC_REPLY;
              addl_words <= 8'h00;
            end else begin
              addl_words <= next_wcount[8:1];
            end
            state <= MRF_FETCH;
          end
        end
        MRF_FETCH: begin
          state <= MRF_LOAD;
        end
        MRF_LOAD: begin
          state <= MRF_PRESENT;
        end
        MRF_PRESENT: begin
          if (tx_ready_i) begin
            if (tx_last_o) begin
              state <= MRF_IDLE;
            end else begin
              idx   <= idx + 9'h001;
              state <= MRF_FETCH;
            end
          end
        end
        default: begin
          state <= MRF_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Response byte output
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_last_o  <= 1'b0;
    end else if (state == MRF_LOAD) begin
      tx_valid_o <= 1'b1;
      tx_last_o  <= (idx == RSP_OFS_PAYLOAD + plen - 9'h001);
      if (idx < RSP_OFS_PAYLOAD) begin
        tx_data_o <= hdr_byte(idx, seq, rsp_size, svc, status, addl_words);
      end else begin
        tx_data_o <= mem_bus.rd_data;
      end
    end else if (state == MRF_PRESENT && tx_ready_i) begin
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
    end
  end

  // ****************************************************************
  // Ready flags and error pulses
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_ready_o         <= 1'b1;
      res_ready_o         <= 1'b0;
      frame_short_error_o <= 1'b0;
      frame_long_error_o  <= 1'b0;
    end else begin
      frame_short_error_o <= 1'b0;
      frame_long_error_o  <= 1'b0;
      if (state == MRF_IDLE && cmd_valid_i) begin
        cmd_ready_o         <= 1'b0;
        res_ready_o         <= !(oversize || mismatch);
        frame_short_error_o <= oversize || (mismatch && !mismatch_long_i);
        frame_long_error_o  <= !oversize && mismatch && mismatch_long_i;
      end else if (state == MRF_COLLECT && res_done_i) begin
        res_ready_o <= 1'b0;
      end else if (state == MRF_PRESENT && tx_ready_i && tx_last_o) begin
        cmd_ready_o <= 1'b1;
      end
    end
  end

endmodule // mrf_framer
`default_nettype wire

// ---- test/mrf_framer_properties.sv ----
// Concurrent checks on the response framer ports
`timescale 1ns/1ns
`default_nettype none
module mrf_framer_properties import mrf_pkg::*; (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  // Command side
  input wire logic        cmd_valid_i,
  input wire logic [15:0] cmd_seq_i,
  input wire logic [7:0]  cmd_svc_i,
  input wire logic [15:0] cmd_size_i,
  input wire logic [15:0] cmd_rx_bytes_i,
  input wire logic        cmd_ready_o,
  input wire logic        mismatch_long_i,
  // Result and transmit side
  input wire logic        res_ready_o,
  input wire logic        res_done_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_last_o,
  input wire logic        tx_ready_i,
  input wire logic        frame_short_error_o,
  input wire logic        frame_long_error_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  logic       take;
  logic       over;
  logic       bad_len;
  logic [8:0] idx;
  logic [15:0] seq_q;
  logic       err_q;
  logic [7:0] svc_q;

  // Command acceptance and size checks
  assign take    = cmd_valid_i && cmd_ready_o;
  assign over    = cmd_rx_bytes_i > MAX_RX_FRAME;
  assign bad_len = (17'(cmd_size_i) + CMD_SIZE_BASE) != 17'(cmd_rx_bytes_i);

  // Byte position within the frame and captured command fields
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx   <= 9'h000;
      seq_q <= 16'h0000;
      err_q <= 1'b0;
      svc_q <= 8'h00;
    end else if (take) begin
      idx   <= 9'h000;
      seq_q <= cmd_seq_i;
      err_q <= over || bad_len;
      svc_q <= cmd_svc_i;
    end else if (tx_valid_o && tx_ready_i) begin
      idx <= idx + 9'h001;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_oversize_short: assert property (take && over |=> frame_short_error_o && !frame_long_error_o && !res_ready_o)
    else $error("oversize command not answered as short frame");
  a_mismatch_long: assert property (take && !over && bad_len && mismatch_long_i |=> frame_long_error_o)
    else $error("size mismatch not answered as long frame");
  a_mismatch_short: assert property (take && !over && bad_len && !mismatch_long_i |=> frame_short_error_o)
    else $error("size mismatch not answered as short frame");
  a_good_collects: assert property (take && !over && !bad_len |=> res_ready_o && !frame_short_error_o)
    else $error("good command did not start result collection");
  a_seq_low_first: assert property (tx_valid_o && idx == 9'h000 |-> tx_data_o == seq_q[7:0])
    else $error("first byte is not sequence low byte");
  a_seq_high_next: assert property (tx_valid_o && idx == 9'h001 |-> tx_data_o == seq_q[15:8])
    else $error("second byte is not sequence high byte");
  a_reserved_zero: assert property (tx_valid_o && idx == 9'h004 |-> tx_data_o == RSVD_VALUE)
    else $error("reserved byte not zero");
  a_error_size: assert property (tx_valid_o && err_q && idx == 9'h002 |-> tx_data_o == 8'h04)
    else $error("error frame size not four");
  a_error_service: assert property (tx_valid_o && err_q && idx == 9'h005 |-> tx_data_o == svc_q)
    else $error("error frame service byte altered");
  a_hold_until_taken: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("response byte changed before acceptance");
  a_done_to_tx: assert property (res_ready_o && res_done_i |=> !res_ready_o ##2 tx_valid_o)
    else $error("frame did not start three cycles after done");
  a_last_frees: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o ##[0:1] cmd_ready_o)
    else $error("command side not freed after last byte");

  // Main scenarios reached
  c_oversize: cover property (take && over);
  c_long: cover property (take && bad_len && mismatch_long_i);
  c_frame_end: cover property (tx_valid_o && tx_ready_i && tx_last_o);
endmodule // mrf_framer_properties

bind mrf_framer mrf_framer_properties u_props (.clock_i, .arst_n_i, .cmd_valid_i, .cmd_seq_i, .cmd_svc_i,
  .cmd_size_i, .cmd_rx_bytes_i, .cmd_ready_o, .mismatch_long_i, .res_ready_o, .res_done_i, .tx_valid_o,
  .tx_data_o, .tx_last_o, .tx_ready_i, .frame_short_error_o, .frame_long_error_o);
`default_nettype wire

// ---- test/mrf_tx_sink.sv ----
// Client side model that takes response bytes, promptly or with stalls
`timescale 1ns/1ns
`default_nettype none
module mrf_tx_sink (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Stall select
  input  wire logic       slow_i,
  // Response byte stream
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  output logic            ready_o
);
  logic [7:0]  got [0:1023];
  logic [15:0] cnt;
  logic [15:0] last_idx;
  logic        phase;

  // Ready every other cycle when slow
  assign ready_o = !slow_i || phase;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
    end
  end

  // Store bytes in wire order, low byte of each field first
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt      <= 16'h0000;
      last_idx <= 16'hFFFF;
    end else if (valid_i && ready_o) begin
      got[cnt[9:0]] <= data_i;
      cnt           <= cnt + 16'h0001;
      if (last_i) begin
        last_idx <= cnt;
      end
    end
  end
endmodule // mrf_tx_sink
`default_nettype wire

// ---- test/mrf_framer_tb_top.sv ----
// Self-checking bench for the response framer
`timescale 1ns/1ns
`default_nettype none
module mrf_framer_tb_top import mrf_pkg::*;;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic [15:0] cmd_seq_i = 16'h0000;
  logic [15:0] cmd_size_i = 16'h0000;
  logic [15:0] cmd_rx_bytes_i = 16'h0000;
  logic [7:0]  cmd_svc_i = 8'h00;
  logic [7:0]  res_data_i = 8'h00;
  logic [7:0]  res_status_i = 8'h00;
  logic        mismatch_long_i = 1'b0;
  logic        res_valid_i = 1'b0;
  logic        res_done_i = 1'b0;
  logic        slow = 1'b0;
  logic        cmd_ready_o, res_ready_o, tx_valid_o, tx_last_o, tx_ready_i;
  logic        frame_short_error_o, frame_long_error_o;
  logic [7:0]  tx_data_o;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          short_seen = 0;
  int          long_seen = 0;

  // Clock
  always #10 clock_i = ~clock_i;

  // Count error pulses from the framer
  always @(posedge clock_i) begin
    if (frame_short_error_o === 1'b1) begin
      short_seen++;
    end
    if (frame_long_error_o === 1'b1) begin
      long_seen++;
    end
  end

  mrf_framer dut (.clock_i, .arst_n_i, .cmd_valid_i, .cmd_seq_i, .cmd_svc_i, .cmd_size_i, .cmd_rx_bytes_i,
    .cmd_ready_o, .mismatch_long_i, .res_valid_i, .res_data_i, .res_ready_o, .res_done_i, .res_status_i,
    .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .frame_short_error_o, .frame_long_error_o);
  mrf_tx_sink sink (.clock_i, .arst_n_i, .slow_i(slow), .valid_i(tx_valid_o), .data_i(tx_data_o),
    .last_i(tx_last_o), .ready_o(tx_ready_i));

  // ****************************************************************
  // Reporting and comparison
  // ****************************************************************
  task final_report;
    $display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One command, its result, and a check of the whole response frame
  task run(input logic [15:0] seq, input logic [7:0] svc, input logic [15:0] sz, input logic [15:0] rx,
           input logic lng, input int n, input logic [7:0] st, input logic slw);
    int base, plen, k, s0, l0;
    logic err, exp_long;
    logic [15:0] rsz;
    base = sink.cnt;
    err  = (rx > MAX_RX_FRAME) || (sz + 16'h0006 != rx);
    exp_long = err && (rx <= MAX_RX_FRAME) && lng;
    s0 = short_seen;
    l0 = long_seen;
    @(posedge clock_i);
    slow <= slw;
    cmd_valid_i <= 1'b1;
    cmd_seq_i <= seq;
    cmd_svc_i <= svc;
    cmd_size_i <= sz;
    cmd_rx_bytes_i <= rx;
    mismatch_long_i <= lng;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    for (k = 0; !err && k < n; k++) begin
      @(posedge clock_i);
      res_valid_i <= 1'b1;
      res_data_i <= 8'(k) ^ 8'h3C;
      res_done_i <= (k == n - 1);
      res_status_i <= st;
    end
    @(posedge clock_i);
    res_valid_i <= 1'b0;
    res_done_i <= 1'b0;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 6000) begin
      @(posedge clock_i);
      k++;
    end
    plen = err ? 0 : (n > 496 ? 496 : n);
    if (!err && st != 8'h00) plen = plen & ~1;
    rsz = 16'(4 + plen);
    chk8("command ready", 8'h01, {7'h00, cmd_ready_o});
    chk8("short pulse", {7'h00, err && !exp_long}, 8'(short_seen - s0));
    chk8("long pulse", {7'h00, exp_long}, 8'(long_seen - l0));
    chk16("frame length", 16'(8 + plen), 16'(sink.cnt - base));
    chk16("last marker", 16'(base + 7 + plen), sink.last_idx);
    chk8("seq low", seq[7:0], sink.got[base]);
    chk8("seq high", seq[15:8], sink.got[base + 1]);
    chk8("size low", rsz[7:0], sink.got[base + 2]);
    chk8("size high", rsz[15:8], sink.got[base + 3]);
    chk8("reserved", RSVD_VALUE, sink.got[base + 4]);
    chk8("service", (err || st != 8'h00) ? svc : (svc | SVC_REPLY), sink.got[base + 5]);
    chk8("status", err ? ((rx <= MAX_RX_FRAME && lng) ? STATUS_LONG : STATUS_SHORT) : st, sink.got[base + 6]);
    chk8("addl count", (!err && st != 8'h00) ? 8'(plen / 2) : 8'h00, sink.got[base + 7]);
    for (k = 0; k < plen; k++) chk8("payload", 8'(k) ^ 8'h3C, sink.got[base + 8 + k]);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_normal;
    run(16'hA55A, 8'h0E, 16'h0008, 16'h000E, 1'b0, 3, STATUS_OK, 1'b0);
    $display("test normal response done");
  endtask

  task t_addl_status;
    run(16'h1234, 8'h4C, 16'h0008, 16'h000E, 1'b0, 5, 8'h1F, 1'b1);
    $display("test additional status done");
  endtask

  task t_oversize;
    run(16'hFFFF, 8'h10, 16'h01F3, 16'h01F9, 1'b1, 0, STATUS_OK, 1'b0);
    $display("test oversize done");
  endtask

  task t_mismatch;
    run(16'h0000, 8'h0E, 16'h0008, 16'h000F, 1'b1, 0, STATUS_OK, 1'b1);
    run(16'h0101, 8'h0E, 16'h0009, 16'h000E, 1'b0, 0, STATUS_OK, 1'b0);
    $display("test size mismatch done");
  endtask

  task t_max_payload;
    run(16'h8001, 8'h01, 16'h01F2, 16'h01F8, 1'b0, 498, STATUS_OK, 1'b1);
    $display("test largest payload done");
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch timeout expected %0d seen %0d", 20000, cycles);
      final_report;
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_normal;
    t_addl_status;
    t_oversize;
    t_mismatch;
    t_max_payload;
    final_report;
  end
endmodule // mrf_framer_tb_top
`default_nettype wire
